// ---- rtl/pxr_pkg.sv ----
package pxr_pkg;

    // ----------------------------------------------------------------
    // sizes and map
    // ----------------------------------------------------------------
    localparam int          PXR_RAM_BYTES     = 512;
    localparam int          PXR_RAM_AW        = 9;
    localparam logic [7:0]  PXR_PAGE_SFR_ADDR = 8'haa;
    localparam logic [7:0]  PXR_PAGE_RESET    = 8'h00;
    localparam int          PXR_PAGE_BIT_POS  = 0;
    localparam int          PXR_READ_LATENCY  = 1;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        valid;    // access strobe, one cycle
        logic        write;    // 1 write, 0 read
        logic        short_ad; // 8-bit indirect address operand
        logic [15:0] addr;     // pointer or low byte in [7:0]
        logic [7:0]  wdata;
    } pxr_xreq_t;

    typedef struct packed {
        logic        valid;    // sfr access strobe
        logic        write;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } pxr_sfr_req_t;

    typedef struct packed {
        logic        valid;    // flash write strobe
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pxr_flash_wr_t;

endpackage

// ---- rtl/pxr_xdata_ram.sv ----
`timescale 1ns/1ps
// Behaviour
// - 512 bytes read/write RAM in xdata space
// - 8-bit access takes high byte from page
// - pointer access to RAM ignores seven top address bits
// - external moves target RAM by default
// - page register upper seven bits read zero
// - page bit picks 256-byte RAM half
// - flash write enable diverts writes to flash
// - reads always come from the RAM
module pxr_xdata_ram #(
    parameter int RAM_BYTES = pxr_pkg::PXR_RAM_BYTES
) (
    input  wire logic                   clk_i,          // system clock
    input  wire logic                   arst_n_i,       // async reset
    input  wire pxr_pkg::pxr_xreq_t     xreq_i,         // core move access
    output logic [7:0]                  xrdata_o,       // read data
    output logic                        xrvalid_o,      // read data valid
    input  wire pxr_pkg::pxr_sfr_req_t  sfr_i,          // core sfr access
    output logic [7:0]                  sfr_rdata_o,    // sfr read data
    output logic                        sfr_hit_o,      // sfr addr decoded
    input  wire logic                   flash_write_enable_bit_i, // flash wr
    output pxr_pkg::pxr_flash_wr_t      flash_wr_o      // to flash control
);
    import pxr_pkg::*;

    // ----------------------------------------------------------------
    // local sizes
    // ----------------------------------------------------------------
    localparam int AW       = PXR_RAM_AW; // ram address bits
    localparam int LOW_BITS = 8;          // bits of a short operand

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // storage and address slice are sized from the package, so another
    // depth would alias silently; refuse it at build time instead
    generate
        if (RAM_BYTES != PXR_RAM_BYTES)
        begin : g_bad_depth
            $error("pxr_xdata_ram: only 512 bytes supported");
        end
        if ((1 << AW) != RAM_BYTES)
        begin : g_bad_width
            $error("pxr_xdata_ram: address width does not fit depth");
        end
        if (AW != LOW_BITS + 1)
        begin : g_bad_page
            $error("pxr_xdata_ram: one page bit must top the low byte");
        end
        if (AW > 16)
        begin : g_bad_span
            $error("pxr_xdata_ram: ram cannot exceed the move space");
        end
        if (PXR_PAGE_BIT_POS != 0)
        begin : g_bad_page_pos
            $error("pxr_xdata_ram: page bit must sit at position 0");
        end
        if (PXR_PAGE_RESET[7:1] != 7'h00)
        begin : g_bad_page_rst
            $error("pxr_xdata_ram: page upper bits must reset to zero");
        end
        if (PXR_READ_LATENCY != 1)
        begin : g_bad_latency
            $error("pxr_xdata_ram: only one-cycle reads are served");
        end
    endgenerate

    // ----------------------------------------------------------------
    // page register
    // ----------------------------------------------------------------
    logic        ram_page_bit_r;
    logic        page_sel;
    logic [7:0]  xdata_page_register;

    logic        page_we;

    // only the page register address is claimed; every other special
    // register belongs to someone else and reads back zero here
    assign page_sel = sfr_i.valid && (sfr_i.addr == PXR_PAGE_SFR_ADDR);
    assign page_we  = page_sel && sfr_i.write;

    // bits 7:1 of a write are dropped; only the page bit is kept

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ram_page_bit_r <= PXR_PAGE_RESET[PXR_PAGE_BIT_POS];
        else if (page_we)
            ram_page_bit_r <= sfr_i.wdata[PXR_PAGE_BIT_POS];
    end

    // ----------------------------------------------------------------
    // special register read
    // ----------------------------------------------------------------
    // upper bits constant zero
    assign xdata_page_register = {7'h00, ram_page_bit_r};
    assign sfr_hit_o   = page_sel;
    assign sfr_rdata_o = page_sel ? xdata_page_register : 8'h00;

    // ----------------------------------------------------------------
    // address forming
    // ----------------------------------------------------------------
    logic [15:0]           full_addr;
    logic [PXR_RAM_AW-1:0] ram_addr;

    // forms the 16-bit move address; a short operand borrows its high
    // byte from the page register, whose upper bits are always zero
    function automatic logic [15:0] form_addr(
        input logic        short_ad,
        input logic [7:0]  page,
        input logic [15:0] addr
    );
        logic [15:0] res;
        if (short_ad)
            res = {page, addr[LOW_BITS-1:0]};
        else
            res = addr;
        return res;
    endfunction

    always_comb
    begin
        full_addr = form_addr(xreq_i.short_ad, xdata_page_register,
                              xreq_i.addr);
    end

    // the top address bits fall away, so the ram repeats across the
    // whole move space and a linear fill may simply run past its end
    assign ram_addr = full_addr[PXR_RAM_AW-1:0];

    // ----------------------------------------------------------------
    // onchip_xdata_ram storage
    // ----------------------------------------------------------------
    logic [7:0] onchip_xdata_ram [PXR_RAM_BYTES];
    logic       ram_we;
    logic       flash_we;

    logic       rd_req;
    logic       wr_req;
    logic [7:0] ram_rword;

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    // classify the move access once so every consumer agrees on it
    assign rd_req   = xreq_i.valid && !xreq_i.write;
    assign wr_req   = xreq_i.valid && xreq_i.write;

    // with flash writes enabled a move write must leave the ram alone
    assign ram_we   = wr_req && !flash_write_enable_bit_i;
    assign flash_we = wr_req && flash_write_enable_bit_i;

    // ram word at the formed address, captured by the read register
    assign ram_rword = onchip_xdata_ram[ram_addr];

    // the array has no reset: a byte is undefined until first written

    always_ff @(posedge clk_i)
    begin
        if (ram_we)
            onchip_xdata_ram[ram_addr] <= xreq_i.wdata;
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // reads always come from the ram, whatever the flash controls say;
    // the data register holds its byte until the next read
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            xrdata_o <= 8'h00;
        else if (rd_req)
            xrdata_o <= ram_rword;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            xrvalid_o <= 1'b0;
        else
            xrvalid_o <= rd_req;
    end

    // ----------------------------------------------------------------
    // flash write redirect
    // ----------------------------------------------------------------
    logic        flash_valid_r;
    logic [15:0] flash_addr_r;
    logic [7:0]  flash_wdata_r;

    // one strobe per diverted move write, a cycle after the core
    // presents it; address and data load only with the strobe
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flash_valid_r <= 1'b0;
        else
            flash_valid_r <= flash_we;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flash_addr_r <= 16'h0000;
        else if (flash_we)
            flash_addr_r <= full_addr;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flash_wdata_r <= 8'h00;
        else if (flash_we)
            flash_wdata_r <= xreq_i.wdata;
    end

    assign flash_wr_o = '{valid: flash_valid_r, addr: flash_addr_r,
                          wdata: flash_wdata_r};

endmodule // pxr_xdata_ram

// ---- verification/pxr_core_model.sv ----
`timescale 1ns/1ps
module pxr_core_model (
    input  wire logic             clk_i,  // clock
    output pxr_pkg::pxr_xreq_t    xreq_o, // move access
    output pxr_pkg::pxr_sfr_req_t sfr_o   // sfr access
);
    initial xreq_o = '0;
    initial sfr_o = '0;
    task automatic mv(logic w, s, logic [15:0] a, logic [7:0] d);
        xreq_o = {1'b1, w, s, a, d};
        @(posedge clk_i) #1;
    endtask
    task automatic stop;
        xreq_o = '0;
        @(posedge clk_i) #1;
    endtask
    task automatic sfr(logic w, logic [7:0] a, d);
        sfr_o = {1'b1, w, a, d};
        @(posedge clk_i) #1 sfr_o = '0;
        @(posedge clk_i) #1;
    endtask
endmodule // pxr_core_model

// ---- verification/pxr_xdata_ram_monitor.sv ----
`timescale 1ns/1ps
module pxr_xdata_ram_monitor (
    input wire logic                  clk_i,       // clock
    input wire logic                  arst_n_i,    // reset
    input wire pxr_pkg::pxr_xreq_t    xreq_i,      // access
    input wire logic [7:0]            xrdata_o,    // read data
    input wire logic                  xrvalid_o,   // read valid
    input wire pxr_pkg::pxr_sfr_req_t sfr_i,       // sfr access
    input wire logic [7:0]            sfr_rdata_o, // sfr data
    input wire logic                  sfr_hit_o,   // sfr hit
    input wire logic                  flash_write_enable_bit_i, // fwe
    input wire pxr_pkg::pxr_flash_wr_t flash_wr_o  // flash write
);
    import pxr_pkg::*;
    wire rd = xreq_i.valid & ~xreq_i.write;
    wire fw = xreq_i.valid & xreq_i.write & flash_write_enable_bit_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_RD: assert property (rd |=> xrvalid_o)
        else $error("no rvalid");
    AST_NORD: assert property (!rd |=> !xrvalid_o)
        else $error("rvalid");
    AST_FW: assert property (fw |=> flash_wr_o.valid
        && flash_wr_o.wdata == $past(xreq_i.wdata)) else $error("flash wr");
    AST_NOFW: assert property (!fw |=> !flash_wr_o.valid)
        else $error("stray flash write");
    AST_FADR: assert property (fw && !xreq_i.short_ad |=>
        flash_wr_o.addr[8:0] == $past(xreq_i.addr[8:0])) else $error("fadr");
    AST_HIT: assert property (sfr_hit_o == (sfr_i.valid
        && sfr_i.addr == 8'haa)) else $error("sfr decode");
    AST_ZERO: assert property (sfr_hit_o |-> sfr_rdata_o[7:1] == 7'h00)
        else $error("page upper bits");
    AST_HOLD: assert property (!xrvalid_o |-> $stable(xrdata_o))
        else $error("rdata moved");
    cover property (fw);
    cover property (rd && xreq_i.short_ad);
    cover property (sfr_hit_o && sfr_rdata_o[0]);
endmodule // pxr_xdata_ram_monitor

// ---- verification/tb_paged_xdata_ram_access.sv ----
`timescale 1ns/1ps
module tb_paged_xdata_ram_access;
    import pxr_pkg::*;
    logic clk_i = 0, arst_n_i = 0, fwe = 0, pg = 0, rvo, hit;
    pxr_xreq_t xq; pxr_sfr_req_t sq; pxr_flash_wr_t fo;
    logic [7:0] rdo, sro, mem [512], rq [$];
    logic [23:0] fq [$];
    int errors = 0, n_checks = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    pxr_core_model core (.clk_i, .xreq_o(xq), .sfr_o(sq));
    pxr_xdata_ram DUT (.clk_i, .arst_n_i, .xreq_i(xq), .xrdata_o(rdo),
        .xrvalid_o(rvo), .sfr_i(sq), .sfr_rdata_o(sro), .sfr_hit_o(hit),
        .flash_write_enable_bit_i(fwe), .flash_wr_o(fo));
    task automatic chk(string n, logic [23:0] e, s);
        n_checks++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic acc(logic w, s, fw, logic [15:0] a, logic [7:0] d);
        logic [15:0] f;
        f = s ? {7'h00, pg, a[7:0]} : a;
        fwe = fw;
        if (!w) rq.push_back(mem[f[8:0]]);
        else if (fw) fq.push_back({f, d});
        else mem[f[8:0]] = d;
        core.mv(w, s, a, d);
    endtask
    task automatic sf(logic w, logic [7:0] a, d);
        core.stop();
        fork core.sfr(w, a, d); join_none
        #4 chk("hit", a == 8'haa, hit);
        chk("sfr", a == 8'haa ? {7'h00, pg} : 8'h00, sro);
        if (w && a == 8'haa) pg = d[0];
        wait fork;
    endtask
    always @(posedge clk_i)
    begin
        if (rvo) chk("rdata", rq.pop_front(), rdo);
        if (fo.valid)
            chk("flash", fq.pop_front(), {fo.addr, fo.wdata});
        if (++cyc > 6000)
        begin
            errors++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(32'had8306eb));
        repeat (4) @(posedge clk_i);
        chk("reset", 24'h0, {rvo, fo.valid, rdo});
        #1 arst_n_i = 1;
        for (int i = 0; i < 512; i++)
            acc(1, 0, 0, 16'($urandom) & 16'hfe00 | 16'(i), 8'($urandom));
        for (int i = 0; i < 1500; i++)
        begin
            if (i % 40 == 0)
            begin
                sf(1, 8'haa, 8'($urandom));
                sf(1'($urandom), 8'($urandom), 8'($urandom));
            end
            acc(1'($urandom), 1'($urandom), $urandom % 4 == 0,
                16'($urandom), 8'($urandom));
        end
        core.stop();
        repeat (3) @(posedge clk_i);
        summarize();
    end
endmodule // tb_paged_xdata_ram_access
bind pxr_xdata_ram pxr_xdata_ram_monitor mon (.clk_i, .arst_n_i, .xreq_i,
    .xrdata_o, .xrvalid_o, .sfr_i, .sfr_rdata_o, .sfr_hit_o,
    .flash_write_enable_bit_i, .flash_wr_o);
